// *** logic/interrupt_priority_select.sv ***
// module: interrupt priority register with two-level arbitration toward the core
// assumes: sources and core handshake run on ref_clk; core pulses irqAck on a taken
// offer and irqReturn when it leaves a service routine
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Priority bit 3 puts the conversion-complete interrupt at low level when clear and high level when set.
// - Priority bit 2 puts the window-compare interrupt at low level when zero and high level when one.
// - Priority bit 1 puts the port match interrupt at low level when zero and high level when one.
// - Priority bit 0 puts the two-wire bus interrupt at low level when written zero, high level when one.
module interrupt_priority_select
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [7:0] rdData,
  input wire logic [3:0] irqReq,
  output logic irqValid,
  output logic [1:0] irqIndex,
  output logic irqHigh,
  input wire logic irqAck,
  input wire logic irqReturn,
  output logic convDonePrioSel,
  output logic windowCmpPrioSel,
  output logic pinMatchPrioSel,
  output logic twowirePrioSel
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] prio;
    logic lowActive;
    logic highActive;
    logic offerValid;
    logic [1:0] offerIdx;
    logic offerHigh;
    logic [7:0] rdData;
  } state_type;

  state_type cur_q;
  state_type nxt_d;

  prio_pick_if pick ();

  assign pick.req = irqReq;
  assign pick.prio = cur_q.prio;

  prio_resolver u_resolver
  (
    .pick(pick)
  );

  logic mayOffer;
  logic prioWrite;
  logic statusRead;
  logic prioRead;

  assign prioWrite = wrStb && (addr == intprio_pkg::PRIO_OFS);
  assign prioRead = rdStb && (addr == intprio_pkg::PRIO_OFS);
  assign statusRead = rdStb && (addr == intprio_pkg::STATUS_OFS);

  // ----------------------------------------------------------------
  // preemption gate
  // ----------------------------------------------------------------
  // preemption gate
  // a high pick only waits for a high service; a low pick waits for any service
  assign mayOffer = pick.pickValid && !cur_q.highActive && (pick.pickHigh || !cur_q.lowActive);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_d = cur_q;

    if (prioWrite)
    begin
      nxt_d.prio = wrData[3:0];
    end

    // leaving a routine ends the innermost level first
    if (irqReturn)
    begin
      if (cur_q.highActive)
      begin
        nxt_d.highActive = 1'b0;
      end
      else
      begin
        nxt_d.lowActive = 1'b0;
      end
    end

    if (irqAck && cur_q.offerValid)
    begin
      if (cur_q.offerHigh)
      begin
        nxt_d.highActive = 1'b1;
      end
      else
      begin
        nxt_d.lowActive = 1'b1;
      end
    end

    // the offer is withdrawn in the ack cycle so the same source is not offered twice
    // before its service level is recorded
    // fixed order offer
    nxt_d.offerValid = mayOffer && !irqAck;
    nxt_d.offerIdx = pick.pickIdx;
    nxt_d.offerHigh = pick.pickHigh;

    nxt_d.rdData = intprio_pkg::RDATA_RESET;
    if (prioRead)
    begin
      nxt_d.rdData = {4'h0, cur_q.prio};
    end
    else if (statusRead)
    begin
      nxt_d.rdData[intprio_pkg::STAT_REQ_LSB +: 4] = irqReq;
      nxt_d.rdData[intprio_pkg::STAT_LOW_ACT_BIT] = cur_q.lowActive;
      nxt_d.rdData[intprio_pkg::STAT_HIGH_ACT_BIT] = cur_q.highActive;
      nxt_d.rdData[intprio_pkg::STAT_OFFER_BIT] = cur_q.offerValid;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cur_q.prio <= intprio_pkg::PRIO_RESET;
      cur_q.lowActive <= 1'b0;
      cur_q.highActive <= 1'b0;
      cur_q.offerValid <= 1'b0;
      cur_q.offerIdx <= 2'h0;
      cur_q.offerHigh <= 1'b0;
      cur_q.rdData <= intprio_pkg::RDATA_RESET;
    end
    else
    begin
      cur_q <= nxt_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdData = cur_q.rdData;
  assign irqValid = cur_q.offerValid;
  assign irqIndex = cur_q.offerIdx;
  assign irqHigh = cur_q.offerHigh;
  assign convDonePrioSel = cur_q.prio[intprio_pkg::CONV_DONE_BIT];
  assign windowCmpPrioSel = cur_q.prio[intprio_pkg::WINDOW_CMP_BIT];
  assign pinMatchPrioSel = cur_q.prio[intprio_pkg::PIN_MATCH_BIT];
  assign twowirePrioSel = cur_q.prio[intprio_pkg::TWOWIRE_BIT];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  conv_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
    prioWrite |=> (convDonePrioSel == $past(wrData[3])) && (rdData == 8'h00))
    else $error("conversion priority bit did not follow the write");

  window_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
    (prioWrite ##1 !prioWrite [*2]) |-> (windowCmpPrioSel == $past(wrData[2], 2)))
    else $error("window priority bit lost or changed without a write");

  match_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
    !prioWrite |=> $stable(pinMatchPrioSel))
    else $error("match priority bit changed without a write");

  twowire_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
    (prioWrite && !wrData[0]) ##1 prioRead |=> !rdData[0] && !twowirePrioSel)
    else $error("two-wire priority bit not low after writing zero");

  high_preempt_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cur_q.lowActive && !cur_q.highActive && ((irqReq & cur_q.prio) != 4'h0) && !irqAck)
    |=> irqValid && irqHigh)
    else $error("high request did not preempt low service");

  low_blocked_a: assert property (@(posedge ref_clk) disable iff (rst)
    irqValid && !irqHigh |-> $past(!cur_q.lowActive && !cur_q.highActive && ((irqReq & cur_q.prio) == 4'h0)))
    else $error("low request offered while blocked or beside a high one");

  fixed_order_a: assert property (@(posedge ref_clk) disable iff (rst)
    irqValid |-> (((irqHigh ? $past(irqReq & cur_q.prio) : $past(irqReq & ~cur_q.prio)) >> irqIndex) == 4'h1))
    else $error("offered source not first in fixed order");

  ack_withdraw_a: assert property (@(posedge ref_clk) disable iff (rst)
    irqValid && irqAck |=> !irqValid && ($past(irqHigh) ? cur_q.highActive : cur_q.lowActive))
    else $error("offer not withdrawn or level not recorded on ack");

  conv_high_a: assert property (@(posedge ref_clk) disable iff (rst)
    (prioWrite && wrData[intprio_pkg::CONV_DONE_BIT]) |=> convDonePrioSel)
    else $error("conversion priority bit not high after writing one");

  match_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
    prioWrite |=> (pinMatchPrioSel == $past(wrData[intprio_pkg::PIN_MATCH_BIT])))
    else $error("match priority bit did not follow the write");

  // a high service blocks every new offer until the core leaves it
  high_blocks_a: assert property (@(posedge ref_clk) disable iff (rst)
    cur_q.highActive |=> !irqValid)
    else $error("offer raised during high service");

endmodule : interrupt_priority_select
`default_nettype wire

// *** common/intprio_pkg.sv ***
// package: register map, field positions and reset values of the interrupt priority select block
// assumes: 8-bit register port, four interrupt sources indexed by their priority bit
package intprio_pkg;

  localparam int NUM_SRC = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [7:0] PRIO_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;

  // priority register field positions
  localparam int CONV_DONE_BIT = 3;
  localparam int WINDOW_CMP_BIT = 2;
  localparam int PIN_MATCH_BIT = 1;
  localparam int TWOWIRE_BIT = 0;

  // status register field positions
  localparam int STAT_REQ_LSB = 0;
  localparam int STAT_LOW_ACT_BIT = 4;
  localparam int STAT_HIGH_ACT_BIT = 5;
  localparam int STAT_OFFER_BIT = 6;

  // values after reset
  localparam logic [3:0] PRIO_RESET = 4'h0;
  localparam logic [7:0] RDATA_RESET = 8'h00;

endpackage : intprio_pkg

// *** common/prio_pick_if.sv ***
// interface: request and priority vectors in, one resolved winner out
// assumes: purely combinational resolver on the same clock as its user
`timescale 1ns/10ps
`default_nettype none
interface prio_pick_if;
  logic [3:0] req;
  logic [3:0] prio;
  logic pickValid;
  logic [1:0] pickIdx;
  logic pickHigh;

  modport user (output req, output prio, input pickValid, input pickIdx, input pickHigh);
  modport resolver (input req, input prio, output pickValid, output pickIdx, output pickHigh);
endinterface : prio_pick_if
`default_nettype wire

// *** logic/prio_resolver.sv ***
// module: picks one pending source, high level before low, higher index first within a level
// assumes: request levels already on the local clock; no state of its own
`timescale 1ns/10ps
`default_nettype none
module prio_resolver
(
  prio_pick_if.resolver pick
);

  logic [3:0] hiReq;
  logic [3:0] loReq;
  logic [3:0] hiWin;
  logic [3:0] loWin;

  assign hiReq = pick.req & pick.prio;
  assign loReq = pick.req & ~pick.prio;

  // ----------------------------------------------------------------
  // fixed order inside each level
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_win
      assign hiWin[i] = hiReq[i] && ((hiReq >> (i + 1)) == 4'h0);
      assign loWin[i] = loReq[i] && ((loReq >> (i + 1)) == 4'h0);
    end
  endgenerate

  always_comb
  begin
    pick.pickValid = (hiReq != 4'h0) || (loReq != 4'h0);
    pick.pickHigh = (hiReq != 4'h0);
    pick.pickIdx = 2'h0;
    for (int k = 0; k < 4; k++)
    begin
      if (pick.pickHigh ? hiWin[k] : loWin[k])
      begin
        pick.pickIdx = 2'(k);
      end
    end
  end

endmodule : prio_resolver
`default_nettype wire

// *** test/core_model.sv ***
// core model: takes an offer on command and leaves a service routine on command
// assumes: bench raises take and leave just after a rising edge of ref_clk
`timescale 1ns/10ps
`default_nettype none
module core_model
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic irqValid,
  input wire logic take,
  input wire logic leave,
  output logic irqAck,
  output logic irqReturn
);
  // one-cycle pulses; no second ack while the offer is being withdrawn
  always_ff @(posedge ref_clk)
  begin
    irqAck <= !rst && take && irqValid && !irqAck;
    irqReturn <= !rst && leave && !irqReturn;
  end
endmodule : core_model
`default_nettype wire

// *** test/interrupt_priority_select_test.sv ***
// testbench: priority register access and two-level offers toward the core
// assumes: core_model answers offers; queues pair expected and seen results
`timescale 1ns/10ps
`default_nettype none
module interrupt_priority_select_test;
  logic ref_clk = 0, rst = 1, wrStb = 0, rdStb = 0, take = 0, leave = 0, rdPend = 0;
  logic [7:0] addr = 8'h00, wrData = 8'h00, rdData, v;
  logic [3:0] irqReq = 4'h0;
  logic [1:0] irqIndex;
  logic irqValid, irqHigh, irqAck, irqReturn, convSel, winSel, pinSel, twoSel;
  logic [7:0] rq[$], oq[$];
  int error_cnt = 0, n_compared = 0;
  always #25 ref_clk = !ref_clk;
  interrupt_priority_select DUT (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb), .rdData(rdData), .irqReq(irqReq), .irqValid(irqValid), .irqIndex(irqIndex),
    .irqHigh(irqHigh), .irqAck(irqAck), .irqReturn(irqReturn), .convDonePrioSel(convSel),
    .windowCmpPrioSel(winSel), .pinMatchPrioSel(pinSel), .twowirePrioSel(twoSel));
  core_model core (.ref_clk(ref_clk), .rst(rst), .irqValid(irqValid), .take(take), .leave(leave),
    .irqAck(irqAck), .irqReturn(irqReturn));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out;
    if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    rdStb <= 1'h0;
    wrStb <= 1'h1;
    addr <= a;
    wrData <= d;
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rq.push_back(exp);
    wrStb <= 1'h0;
    rdStb <= 1'h1;
    addr <= a;
    @(posedge ref_clk);
  endtask : rd
  // strobes stay up across back-to-back transfers, so each strobe is assigned once per step
  task automatic idle;
    wrStb <= 1'h0;
    rdStb <= 1'h0;
  endtask : idle
  // offer expected as {high, index}; the core acks it as soon as it stands
  task automatic accept(input logic [7:0] exp);
    int n;
    n = 0;
    oq.push_back(exp);
    take <= 1'h1;
    do @(posedge ref_clk); while (irqAck !== 1'h1 && n++ < 20);
    take <= 1'h0;
    if (irqAck !== 1'h1)
      check({7'h00, irqAck}, 8'h01, "irqAck");
  endtask : accept
  task automatic ret;
    leave <= 1'h1;
    @(posedge ref_clk);
    leave <= 1'h0;
    repeat (3) @(posedge ref_clk);
  endtask : ret
  // ----------------------------------------
  // monitor: read data lives one cycle only
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    // outputs are unknown until the first reset edge has passed
    if (!rst)
    begin
      if (rdPend)
        check(rdData, rq.pop_front(), "rdData");
      else
        check(rdData, 8'h00, "rdData idle");
      if (irqAck === 1'h1)
        check({5'h00, irqHigh, irqIndex}, oq.pop_front(), "offer");
    end
    rdPend <= rdStb;
  end
  initial
  begin
    #200000;
    error_cnt++;
    close_out();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(65));
    repeat (5) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    rd(intprio_pkg::PRIO_OFS, 8'h00);
    rd(intprio_pkg::STATUS_OFS, 8'h00);
    rd(8'h08, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      v = 8'h01 << i;
      wr(intprio_pkg::PRIO_OFS, v | (8'($urandom) & 8'hF0));
      idle();
      @(posedge ref_clk);
      check({4'h0, convSel, winSel, pinSel, twoSel}, v, "prio outputs");
      rd(intprio_pkg::PRIO_OFS, v);
    end
    // unmapped write must leave the register alone
    wr(8'h08, 8'h0F);
    rd(intprio_pkg::PRIO_OFS, 8'h08);
    v = 8'($urandom) & 8'h0F;
    wr(intprio_pkg::PRIO_OFS, v);
    rd(intprio_pkg::PRIO_OFS, v);
    wr(intprio_pkg::PRIO_OFS, 8'h00);
    rd(intprio_pkg::PRIO_OFS, 8'h00);
    idle();
    irqReq <= 4'hF;
    repeat (3) @(posedge ref_clk);
    accept(8'h03);
    repeat (3) @(posedge ref_clk);
    check({7'h00, irqValid}, 8'h00, "low held off");
    rd(intprio_pkg::STATUS_OFS, 8'h1F);
    // high level must preempt the low routine still in service
    wr(intprio_pkg::PRIO_OFS, 8'h01);
    idle();
    repeat (3) @(posedge ref_clk);
    accept(8'h04);
    irqReq <= 4'hE;
    ret();
    check({7'h00, irqValid}, 8'h00, "low still busy");
    irqReq <= 4'h6;
    ret();
    accept(8'h02);
    irqReq <= 4'h0;
    ret();
    close_out();
  end
endmodule : interrupt_priority_select_test
`default_nettype wire
